// ==== include/csss_pkg.sv ====
// Constants, types and encodings for the clock source select and start-up block
//
// How it works
// - Crystal, select bit 0: wake 1K cycles; reset 14 cycles plus 0, 4.1 or 65 ms; 11 reserved.
// - Crystal, select bit 1: wake 32K cycles; reset 14 cycles plus 0, 4.1 or 65 ms; 11 reserved.
// - Source code 0010 selects the calibrated 8 MHz internal RC oscillator, no external parts.
// - Delivered configuration is source 0010 and start-up time code 10.
// - Every reset copies the factory calibration value into the RC trim register.
// - Software may write the RC trim register at run time, replacing the factory value.
// - The watchdog oscillator clocks the watchdog and reset time-out whatever the system source.
// - RC oscillator: wake 6 cycles; reset 14 cycles plus 0, 4.1 or 65 ms; 11 reserved.
// - Source code 0011 selects the 128 kHz internal oscillator.
// - 128 kHz oscillator: wake 6 cycles; reset 14 cycles plus 0, 4 or 64 ms; 11 reserved.
// - Source code 0000 takes the system clock from the crystal input pin.
// - External clock: wake 6 cycles; reset 14 cycles plus 0, 4.1 or 65 ms; 11 reserved.
// - Prescaler select resets to 0011 with divide-by-eight programmed and to 0000 otherwise.
// - Trim bit 7 picks the range; bits 6 to 0 tune from 0x00 lowest to 0x7F highest in it.
`default_nettype none
package csss_pkg;
  localparam logic [3:0] SRC_EXTERNAL = 4'h0;
  localparam logic [3:0] SRC_RC = 4'h2;
  localparam logic [3:0] SRC_LP128 = 4'h3;
  localparam logic [3:0] SRC_LF_XTAL_DEFAULT = 4'h6;

  localparam logic [3:0] DELIVERED_SRC = 4'h2;
  localparam logic [1:0] DELIVERED_SUT = 2'h2;
  localparam logic DELIVERED_SEL_BIT = 1'b0;
  localparam logic DELIVERED_DIV8 = 1'b1;

  localparam logic [1:0] SUT_BASE_ONLY = 2'h0;
  localparam logic [1:0] SUT_SHORT = 2'h1;
  localparam logic [1:0] SUT_LONG = 2'h2;

  localparam logic [3:0] PRESC_DIV1 = 4'h0;
  localparam logic [3:0] PRESC_DIV8 = 4'h3;
  localparam logic [7:0] TRIM_RESET = 8'h00;
  localparam int TRIM_RANGE_BIT = 7;

  localparam int RESET_BASE_CYCLES = 14;
  localparam int WAKE_FAST_CYCLES = 6;
  localparam int WAKE_LF_SHORT_CYCLES = 1024;
  localparam int WAKE_LF_LONG_CYCLES = 32768;

  localparam int WDT_OSC_HZ = 128000;
  localparam int TIMEOUT_SHORT_US = 4100;
  localparam int TIMEOUT_LONG_US = 65000;
  localparam int LP_TIMEOUT_SHORT_US = 4000;
  localparam int LP_TIMEOUT_LONG_US = 64000;
  localparam int CAPTURE_WAIT_CYCLES = 3;

  // Rounded up: a time-out must never come out short
  function automatic int us_to_ticks(input int us, input int hz);
    longint prod;
    prod = longint'(us) * longint'(hz) + 64'd999999;
    return int'(prod / 64'd1000000);
  endfunction : us_to_ticks

  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_TRIM = 8'h04;
  localparam logic [7:0] ADDR_PRESC = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam int CTRL_SLEEP_BIT = 0;
  localparam int STATUS_STATE_LSB = 0;
  localparam int STATUS_RELEASE_BIT = 7;
  localparam int STATUS_SRC_LSB = 8;
  localparam int STATUS_SEL_BIT = 12;
  localparam int STATUS_SUT_LSB = 13;
  localparam int STATUS_DIV8_BIT = 15;

  localparam int OSC_EXT = 0;
  localparam int OSC_RC = 1;
  localparam int OSC_LP = 2;
  localparam int OSC_LF = 3;
  localparam int OSC_WDT = 4;
  localparam int OSC_COUNT = 5;

  typedef enum logic [6:0] {
    ST_LOAD = 7'b000_0001,
    ST_RST_COUNT = 7'b000_0010,
    ST_RST_TIMEOUT = 7'b000_0100,
    ST_RUN = 7'b000_1000,
    ST_SLEEP = 7'b001_0000,
    ST_WAKE = 7'b010_0000,
    ST_FAULT = 7'b100_0000
  } csss_state_type;

  typedef struct packed {
    logic [3:0] src;
    logic sel_bit;
    logic [1:0] startup_time_field;
    logic div8;
  } csss_cfg_type;
endpackage : csss_pkg
`default_nettype wire

// ==== rtl/csss_tick_sync.sv ====
// Two-stage synchroniser with rising-edge pulse for one oscillator line
`timescale 1ns/1ps
`default_nettype none
module csss_tick_sync
  import csss_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic osc_i,
  output logic tick_o
);
  logic meta;
  logic sync;
  logic last;

  // First stage feeds only the second
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      meta <= 1'b0;
      sync <= 1'b0;
      last <= 1'b0;
    end
    else
    begin
      meta <= osc_i;
      sync <= meta;
      last <= sync;
    end
  end

  assign tick_o = sync & ~last;
endmodule : csss_tick_sync
`default_nettype wire

// ==== rtl/csss_clock_control.sv ====
// Clock source selection, start-up delay sequencing, trim and prescaler registers
`timescale 1ns/1ps
`default_nettype none
module csss_clock_control
  import csss_pkg::*;
#(
  parameter logic [3:0] LF_XTAL_CODE = SRC_LF_XTAL_DEFAULT,
  parameter int WDT_HZ = WDT_OSC_HZ,
  parameter int LF_LONG_WAKE = WAKE_LF_LONG_CYCLES,
  parameter int TO_SHORT_TICKS = us_to_ticks(TIMEOUT_SHORT_US, WDT_HZ),
  parameter int TO_LONG_TICKS = us_to_ticks(TIMEOUT_LONG_US, WDT_HZ),
  parameter int LP_SHORT_TICKS = us_to_ticks(LP_TIMEOUT_SHORT_US, WDT_HZ),
  parameter int LP_LONG_TICKS = us_to_ticks(LP_TIMEOUT_LONG_US, WDT_HZ)
)
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire csss_cfg_type cfg_fuse_i,
  input wire logic [7:0] factory_trim_i,
  input wire logic crystal_input_pin_i,
  input wire logic rc_osc_i,
  input wire logic lp_osc_i,
  input wire logic lf_osc_i,
  input wire logic wdt_osc_i,
  input wire logic wake_i,
  output logic sys_clk_release_o,
  output logic [3:0] src_onehot_o,
  output logic [7:0] rc_trim_register_o,
  output logic [3:0] prescaler_select_field_o,
  output logic wdt_tick_o
);
  localparam int CNT_W = 17;

  csss_state_type state;
  csss_state_type next_state;
  csss_cfg_type cfg_meta;
  csss_cfg_type cfg_sync;
  csss_cfg_type cfg;
  logic [7:0] trim_meta;
  logic [7:0] trim_sync;
  logic wake_meta;
  logic wake_sync;
  logic [OSC_COUNT-1:0] osc_raw;
  logic [OSC_COUNT-1:0] osc_tick;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] wake_target;
  logic [CNT_W-1:0] timeout_target;
  logic [1:0] load_wait;
  logic sel_tick;
  logic cfg_valid;
  logic is_lp;
  logic sleep_req;
  logic apb_setup;
  logic apb_write;
  logic [31:0] status_word;

  assign osc_raw = {wdt_osc_i, lf_osc_i, lp_osc_i, rc_osc_i, crystal_input_pin_i};

  genvar g;
  generate
    for (g = 0; g < OSC_COUNT; g++)
    begin : g_osc
      csss_tick_sync u_sync (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .osc_i(osc_raw[g]),
        .tick_o(osc_tick[g])
      );
    end
  endgenerate

  // Fuses, factory trim and wake pin are static or slow but still cross in
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      cfg_meta <= '0;
      cfg_sync <= '0;
      trim_meta <= TRIM_RESET;
      trim_sync <= TRIM_RESET;
      wake_meta <= 1'b0;
      wake_sync <= 1'b0;
    end
    else
    begin
      cfg_meta <= cfg_fuse_i;
      cfg_sync <= cfg_meta;
      trim_meta <= factory_trim_i;
      trim_sync <= trim_meta;
      wake_meta <= wake_i;
      wake_sync <= wake_meta;
    end
  end

  // Configuration is captured once per reset, after the synchroniser has settled
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      load_wait <= 2'h0;
      cfg <= '{src: DELIVERED_SRC, sel_bit: DELIVERED_SEL_BIT, startup_time_field: DELIVERED_SUT,
               div8: DELIVERED_DIV8};
    end
    else if (state == ST_LOAD)
    begin
      load_wait <= load_wait + 2'h1;
      if (load_wait == 2'(CAPTURE_WAIT_CYCLES - 1))
      begin
        cfg <= cfg_sync;
      end
    end
  end

  // Source decode; the low-frequency crystal code is a parameter
  always_comb
  begin
    is_lp = 1'b0;
    cfg_valid = (cfg.startup_time_field != 2'h3);
    sel_tick = 1'b0;
    wake_target = CNT_W'(WAKE_FAST_CYCLES);
    if (cfg.src == SRC_RC)
    begin
      sel_tick = osc_tick[OSC_RC];
    end
    else if (cfg.src == SRC_LP128)
    begin
      sel_tick = osc_tick[OSC_LP];
      is_lp = 1'b1;
    end
    else if (cfg.src == SRC_EXTERNAL)
    begin
      sel_tick = osc_tick[OSC_EXT];
    end
    else if (cfg.src == LF_XTAL_CODE)
    begin
      sel_tick = osc_tick[OSC_LF];
      wake_target = cfg.sel_bit ? CNT_W'(LF_LONG_WAKE) : CNT_W'(WAKE_LF_SHORT_CYCLES);
    end
    else
    begin
      cfg_valid = 1'b0;
    end
  end

  // The 128 kHz source has its own, slightly shorter time-outs
  always_comb
  begin
    if (cfg.startup_time_field == SUT_SHORT)
    begin
      timeout_target = is_lp ? CNT_W'(LP_SHORT_TICKS) : CNT_W'(TO_SHORT_TICKS);
    end
    else if (cfg.startup_time_field == SUT_LONG)
    begin
      timeout_target = is_lp ? CNT_W'(LP_LONG_TICKS) : CNT_W'(TO_LONG_TICKS);
    end
    else
    begin
      timeout_target = '0;
    end
  end

  // Start-up sequencer
  always_comb
  begin
    next_state = state;
    case (state)
      ST_LOAD:
      begin
        if (load_wait == 2'(CAPTURE_WAIT_CYCLES - 1))
        begin
          next_state = ST_RST_COUNT;
        end
      end
      ST_RST_COUNT:
      begin
        if (!cfg_valid)
        begin
          next_state = ST_FAULT;
        end
        else if (sel_tick && cnt == CNT_W'(RESET_BASE_CYCLES - 1))
        begin
          next_state = (cfg.startup_time_field == SUT_BASE_ONLY) ? ST_RUN : ST_RST_TIMEOUT;
        end
      end
      ST_RST_TIMEOUT:
      begin
        // Timed on the watchdog oscillator, not the system source
        if (osc_tick[OSC_WDT] && cnt == timeout_target - CNT_W'(1))
        begin
          next_state = ST_RUN;
        end
      end
      ST_RUN:
      begin
        if (sleep_req)
        begin
          next_state = ST_SLEEP;
        end
      end
      ST_SLEEP:
      begin
        if (wake_sync)
        begin
          next_state = ST_WAKE;
        end
      end
      ST_WAKE:
      begin
        if (sel_tick && cnt == wake_target - CNT_W'(1))
        begin
          next_state = ST_RUN;
        end
      end
      ST_FAULT:
      begin
        next_state = ST_FAULT;
      end
      default:
      begin
        next_state = ST_FAULT;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      state <= ST_LOAD;
    end
    else
    begin
      state <= next_state;
    end
  end

  // One counter serves the reset, time-out and wake phases (load uses load_wait); it restarts on every state change
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      cnt <= '0;
    end
    else if (next_state != state)
    begin
      cnt <= '0;
    end
    else if ((state == ST_RST_COUNT || state == ST_WAKE) && sel_tick)
    begin
      cnt <= cnt + CNT_W'(1);
    end
    else if (state == ST_RST_TIMEOUT && osc_tick[OSC_WDT])
    begin
      cnt <= cnt + CNT_W'(1);
    end
  end

  // Outputs from flops
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      sys_clk_release_o <= 1'b0;
      src_onehot_o <= 4'h0;
      wdt_tick_o <= 1'b0;
    end
    else
    begin
      sys_clk_release_o <= (next_state == ST_RUN);
      src_onehot_o <= {cfg.src == LF_XTAL_CODE, cfg.src == SRC_LP128,
                       cfg.src == SRC_RC, cfg.src == SRC_EXTERNAL};
      wdt_tick_o <= osc_tick[OSC_WDT];
    end
  end

  // APB slave: one wait-free access phase, pready raised from the setup cycle
  assign apb_setup = psel_i & ~penable_i;
  assign apb_write = psel_i & penable_i & pready_o & pwrite_i;

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      rc_trim_register_o <= TRIM_RESET;
    end
    else if (state == ST_LOAD)
    begin
      rc_trim_register_o <= trim_sync;
    end
    else if (apb_write && paddr_i == ADDR_TRIM)
    begin
      rc_trim_register_o <= pwdata_i[7:0];
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      prescaler_select_field_o <= PRESC_DIV1;
    end
    else if (state == ST_LOAD)
    begin
      prescaler_select_field_o <= cfg_sync.div8 ? PRESC_DIV8 : PRESC_DIV1;
    end
    else if (apb_write && paddr_i == ADDR_PRESC)
    begin
      prescaler_select_field_o <= pwdata_i[3:0];
    end
  end

  // Sleep request is taken only while running, and drops once sleep is entered
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      sleep_req <= 1'b0;
    end
    else if (apb_write && paddr_i == ADDR_CTRL && state == ST_RUN)
    begin
      sleep_req <= pwdata_i[CTRL_SLEEP_BIT];
    end
    else if (state != ST_RUN)
    begin
      sleep_req <= 1'b0;
    end
  end

  always_comb
  begin
    status_word = '0;
    status_word[STATUS_STATE_LSB +: 7] = state;
    status_word[STATUS_RELEASE_BIT] = sys_clk_release_o;
    status_word[STATUS_SRC_LSB +: 4] = cfg.src;
    status_word[STATUS_SEL_BIT] = cfg.sel_bit;
    status_word[STATUS_SUT_LSB +: 2] = cfg.startup_time_field;
    status_word[STATUS_DIV8_BIT] = cfg.div8;
  end

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
    end
    else
    begin
      pready_o <= apb_setup;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
      if (apb_setup)
      begin
        if (paddr_i == ADDR_CTRL)
        begin
          prdata_o <= {31'h0000_0000, sleep_req};
        end
        else if (paddr_i == ADDR_TRIM)
        begin
          prdata_o <= {24'h00_0000, rc_trim_register_o};
        end
        else if (paddr_i == ADDR_PRESC)
        begin
          prdata_o <= {28'h000_0000, prescaler_select_field_o};
        end
        else if (paddr_i == ADDR_STATUS)
        begin
          prdata_o <= status_word;
        end
        else
        begin
          pslverr_o <= 1'b1;
        end
      end
    end
  end
endmodule : csss_clock_control
`default_nettype wire

// ==== dv/csss_clock_control_asserts.sv ====
// Port-level checks for the clock source select and start-up block
`timescale 1ns/1ps
`default_nettype none
module csss_clock_control_asserts
  import csss_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic pready_o,
  input wire csss_cfg_type cfg_fuse_i,
  input wire logic [7:0] factory_trim_i,
  input wire logic wdt_osc_i,
  input wire logic sys_clk_release_o,
  input wire logic [3:0] src_onehot_o,
  input wire logic [7:0] rc_trim_register_o,
  input wire logic [3:0] prescaler_select_field_o,
  input wire logic wdt_tick_o
);
  logic [7:0] wd_q;
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // Write data held one cycle so the trim can be compared after the access edge
  always_ff @(posedge clk_i) wd_q <= pwdata_i[7:0];
  sequence load_done_s;
    $fell(sys_rst_i) ##3 1'b1;
  endsequence
  sequence trim_wr_s;
    psel_i && penable_i && pready_o && pwrite_i && paddr_i == ADDR_TRIM;
  endsequence
  fuse_presc_a: assert property (
    load_done_s |-> prescaler_select_field_o == (cfg_fuse_i.div8 ? 4'h3 : 4'h0))
    else $error("prescaler start value wrong");
  factory_trim_a: assert property (
    load_done_s |-> rc_trim_register_o == factory_trim_i)
    else $error("trim not loaded from factory value");
  trim_write_a: assert property (
    trim_wr_s |=> rc_trim_register_o == wd_q)
    else $error("trim write not taken");
  apb_ready_a: assert property (
    psel_i && !penable_i |=> pready_o)
    else $error("no ready after setup");
  rc_select_a: assert property (
    sys_clk_release_o && cfg_fuse_i.src == 4'h2 |-> src_onehot_o == 4'h2)
    else $error("rc source not decoded");
  lp_select_a: assert property (
    sys_clk_release_o && cfg_fuse_i.src == 4'h3 |-> src_onehot_o == 4'h4)
    else $error("low power source not decoded");
  ext_select_a: assert property (
    sys_clk_release_o && cfg_fuse_i.src == 4'h0 |-> src_onehot_o == 4'h1)
    else $error("external source not decoded");
  lf_select_a: assert property (
    sys_clk_release_o && cfg_fuse_i.src == SRC_LF_XTAL_DEFAULT |-> src_onehot_o == 4'h8)
    else $error("crystal source not decoded");
  reserved_sut_a: assert property (
    cfg_fuse_i.startup_time_field == 2'h3 |-> !sys_clk_release_o)
    else $error("clock released with reserved start-up code");
  wdt_tick_a: assert property (
    $rose(wdt_osc_i) |-> ##[1:5] wdt_tick_o ##1 !wdt_tick_o [*5])
    else $error("watchdog tick missing or too long");
endmodule : csss_clock_control_asserts

bind csss_clock_control csss_clock_control_asserts chk_u (
  .clk_i, .sys_rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
  .pready_o, .cfg_fuse_i, .factory_trim_i, .wdt_osc_i, .sys_clk_release_o,
  .src_onehot_o, .rc_trim_register_o, .prescaler_select_field_o, .wdt_tick_o
);
`default_nettype wire

// ==== dv/csss_osc_model.sv ====
// Free-running oscillator sources seen by the clock control block
`timescale 1ns/1ps
`default_nettype none
module csss_osc_model
(
  output var logic ext_o,
  output var logic rc_o,
  output var logic lp_o,
  output var logic lf_o,
  output var logic wdt_o
);
  // Fixed half periods: no cycle-to-cycle step, phases unrelated to clk_i
  initial
  begin
    ext_o = 1'b0;
    forever #27 ext_o = ~ext_o;
  end
  initial
  begin
    {rc_o, lp_o, lf_o} = 3'h0;
    fork
      forever #35 rc_o = ~rc_o;
      forever #43 lp_o = ~lp_o;
      forever #51 lf_o = ~lf_o;
    join
  end
  // Watchdog source runs whatever the system source is
  initial
  begin
    wdt_o = 1'b0;
    forever #59 wdt_o = ~wdt_o;
  end
endmodule : csss_osc_model
`default_nettype wire

// ==== dv/csss_tb_top.sv ====
// Self-checking bench for clock source selection and start-up sequencing
`timescale 1ns/1ps
`default_nettype none
module csss_tb_top
  import csss_pkg::*;
;
  typedef struct {
    csss_cfg_type cfg;
    logic [3:0] oh;
    int ticks;
    int hp;
    int wake;
  } csss_row_type;
  localparam int HW = 59;
  logic clk_i = 1'b0, sys_rst_i = 1'b1, wake_i = 1'b0;
  logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00, factory_trim_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0000_0000;
  logic [31:0] prdata_o;
  logic pready_o, pslverr_o, rel_o, ext_w, rc_w, lp_w, lf_w, wdt_w;
  logic [3:0] oh_o, presc_o;
  logic [7:0] trim_o;
  csss_cfg_type cfg_fuse_i = '0;
  int n_fail = 0, total_checks = 0;
  csss_row_type rows[8] = '{
    '{'{4'h2, 1'b0, 2'h0, 1'b1}, 4'h2, 0, 35, 6},
    '{'{4'h2, 1'b0, 2'h2, 1'b0}, 4'h2, 8, 35, 6},
    '{'{4'h3, 1'b0, 2'h1, 1'b1}, 4'h4, 4, 43, 6},
    '{'{4'h3, 1'b0, 2'h2, 1'b0}, 4'h4, 7, 43, 6},
    '{'{4'h0, 1'b0, 2'h1, 1'b0}, 4'h1, 5, 27, 6},
    '{'{4'h0, 1'b1, 2'h0, 1'b1}, 4'h1, 0, 27, 6},
    '{'{4'h6, 1'b1, 2'h0, 1'b1}, 4'h8, 0, 51, 40},
    '{'{4'h6, 1'b0, 2'h2, 1'b0}, 4'h8, 8, 51, 1024}};
  csss_osc_model osc_u (.ext_o(ext_w), .rc_o(rc_w), .lp_o(lp_w), .lf_o(lf_w), .wdt_o(wdt_w));
  csss_clock_control #(.LF_LONG_WAKE(40), .TO_SHORT_TICKS(5), .TO_LONG_TICKS(8),
    .LP_SHORT_TICKS(4), .LP_LONG_TICKS(7)) dut_u (
    .clk_i, .sys_rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .prdata_o, .pready_o, .pslverr_o, .cfg_fuse_i, .factory_trim_i,
    .crystal_input_pin_i(ext_w), .rc_osc_i(rc_w), .lp_osc_i(lp_w), .lf_osc_i(lf_w),
    .wdt_osc_i(wdt_w), .wake_i, .sys_clk_release_o(rel_o), .src_onehot_o(oh_o),
    .rc_trim_register_o(trim_o), .prescaler_select_field_o(presc_o), .wdt_tick_o());
  initial
  begin
    forever #4 clk_i = ~clk_i;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : tally_and_finish
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    // No wait count assumed: only the watchdog ends a stuck access
    @(posedge clk_i);
    while (pready_o !== 1'b1)
      @(posedge clk_i);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb
  task automatic do_reset();
    sys_rst_i <= 1'b1;
    repeat (20) @(posedge clk_i);
    sys_rst_i <= 1'b0;
  endtask : do_reset
  task automatic wait_rel(input logic v, output longint t);
    for (int i = 0; i < 20000 && rel_o !== v; i++)
      @(posedge clk_i);
    if (rel_o !== v)
      chk({31'h0, rel_o}, {31'h0, v});
    t = $time;
  endtask : wait_rel
  // Tolerances cover oscillator phase and the synchroniser delay
  initial
  begin
    longint t0, t1, e, h;
    logic [31:0] rd;
    logic er;
    for (int i = 0; i < 8; i++)
    begin
      cfg_fuse_i <= rows[i].cfg;
      factory_trim_i <= 8'h40 + 8'(i);
      do_reset();
      t0 = $time;
      h = rows[i].hp;
      wait_rel(1'b1, t1);
      e = 28 * h + 2 * HW * rows[i].ticks;
      chk(32'(t1 - t0 >= e - 2 * h - 2 * HW && t1 - t0 <= e + 2 * h + 2 * HW + 120), 32'h1);
      chk({28'h0, oh_o}, {28'h0, rows[i].oh});
      chk({24'h0, trim_o}, 32'h40 + i);
      chk({28'h0, presc_o}, rows[i].cfg.div8 ? 32'h3 : 32'h0);
      apb(1'b0, ADDR_STATUS, 32'h0, rd, er);
      chk(rd, {16'h0, rows[i].cfg.div8, rows[i].cfg.startup_time_field, rows[i].cfg.sel_bit,
               rows[i].cfg.src, 8'h88});
      apb(1'b1, ADDR_CTRL, 32'h1, rd, er);
      wait_rel(1'b0, t1);
      wake_i <= 1'b1;
      t0 = $time;
      wait_rel(1'b1, t1);
      wake_i <= 1'b0;
      e = 2 * h * rows[i].wake;
      chk(32'(t1 - t0 >= e - 2 * h && t1 - t0 <= e + 2 * h + 100), 32'h1);
    end
    for (int k = 0; k < 2; k++)
    begin
      cfg_fuse_i <= k ? csss_cfg_type'{4'h2, 1'b0, 2'h3, 1'b1}
                      : csss_cfg_type'{4'h1, 1'b0, 2'h0, 1'b1};
      do_reset();
      repeat (400) @(posedge clk_i);
      apb(1'b0, ADDR_STATUS, 32'h0, rd, er);
      chk({25'h0, rd[6:0]}, 32'h40);
      chk({31'h0, rel_o}, 32'h0);
    end
    cfg_fuse_i <= rows[1].cfg;
    do_reset();
    // Read while still loading: delivered settings stand until the fuses are taken
    apb(1'b0, ADDR_STATUS, 32'h0, rd, er);
    chk(rd, {16'h0, DELIVERED_DIV8, DELIVERED_SUT, DELIVERED_SEL_BIT,
             DELIVERED_SRC, 8'h01});
    wait_rel(1'b1, t1);
    for (int k = 0; k < 2; k++)
    begin
      apb(1'b1, ADDR_TRIM, k ? 32'h0000_007f : 32'h0000_0180, rd, er);
      apb(1'b0, ADDR_TRIM, 32'h0, rd, er);
      chk(rd, k ? 32'h7f : 32'h80);
    end
    apb(1'b1, ADDR_PRESC, 32'h9, rd, er);
    // The write lands at the access edge; look once it has settled
    @(posedge clk_i);
    chk({28'h0, presc_o}, 32'h9);
    apb(1'b0, 8'h10, 32'h0, rd, er);
    chk({er, rd[30:0]}, 32'h8000_0000);
    tally_and_finish();
  end
  initial
  begin
    repeat (90000) @(posedge clk_i);
    n_fail++;
    tally_and_finish();
  end
endmodule : csss_tb_top
`default_nettype wire
